// file: logic/ext_mem_strobe_timing.sv
/*
 * Strobe timing sequencer of the external memory interface: decodes each
 * data move, routes it on-chip or off-chip and sequences address, latch
 * enable, read/write strobe and hold, all in system clock cycles.
 * Assumes the core raises move_req_in for one cycle while move_busy_out is
 * low, and leaves the registers alone while a move is in flight.
 */
// What this block does
// - setup bits 7:6, strobe width 5:2, hold 1:0; latch width from config
// - strobe stays low for width field plus one cycle, 1 to 16
// - off-chip move takes four plus setup, strobe, hold and latch cycles
// - non-multiplexed move with minimum settings completes in five cycles
// - multiplexed latch phases add at least two cycles, minimum seven
// - after reset timing register reads all ones, maximum delays
// - latch enable high lasts one to four cycles per width setting
// - latch enable low phase lasts the same one to four cycles
// - write data valid one to nineteen cycles before write strobe rises
// - write data stays driven zero to three cycles after strobe, per hold
// - mode codes 101, 110, 111 give separate address and data pins
// - mode codes 001, 010, 011 share low address and data pins
// - code 110 eight-bit moves take upper address from bank select
// - cleared multiplex bit selects shared pins, set bit separate pins
// - low address on shared pins while latch high, data around strobe
// - memory mode 00 keeps every move on-chip, no external strobe
module ext_mem_strobe_timing (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   // register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   // data move requests from the core
   input wire logic move_req_in,
   input wire logic move_write_in,
   input wire logic move_wide_in,
   input wire logic [15:0] move_addr_in,
   input wire logic [7:0] move_wdata_in,
   output logic move_busy_out,
   output logic move_done_out,
   output logic [7:0] move_rdata_out,
   output logic onchip_sel_out,
   // external memory pins
   output logic [15:0] addr_out,
   output logic addr_lo_oe_n_out,
   output logic addr_hi_oe_n_out,
   output logic [7:0] ad_out,
   output logic ad_oe_n_out,
   input wire logic [7:0] ad_in,
   output logic ale_out,
   output logic rd_n_out,
   output logic wr_n_out
);
   import ext_mem_pkg::*;

   // ==========================================================
   // registers and pin synchroniser
   logic [7:0] timing_reg;
   logic [7:0] config_reg;
   logic [7:0] bank_reg;
   logic [7:0] ad_sync;

   ext_mem_regs u_regs (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .sfr_addr_in(sfr_addr_in),
      .sfr_wr_in(sfr_wr_in),
      .sfr_rd_in(sfr_rd_in),
      .sfr_wdata_in(sfr_wdata_in),
      .sfr_rdata_out(sfr_rdata_out),
      .timing_out(timing_reg),
      .config_out(config_reg),
      .bank_out(bank_reg)
   );

   ext_mem_pin_sync u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .pin_in(ad_in),
      .sync_out(ad_sync)
   );

   // ==========================================================
   // field decode
   logic [1:0] setup_field;
   logic [3:0] width_field;
   logic [1:0] hold_field;
   logic [1:0] ale_field;
   logic [1:0] mode_field;
   logic separate_pins;

   assign setup_field = timing_reg[SETUP_MSB:SETUP_LSB];
   assign width_field = timing_reg[WIDTH_MSB:WIDTH_LSB];
   assign hold_field = timing_reg[HOLD_MSB:HOLD_LSB];
   assign ale_field = config_reg[ALE_MSB:ALE_LSB];
   assign mode_field = config_reg[MODE_MSB:MODE_LSB];
   // zero means shared address/data pins
   assign separate_pins = config_reg[MUX_BIT];

   // ==========================================================
   // request decode: effective address and on/off-chip routing
   seq_state_t state;
   seq_state_t next_state;
   logic take;
   logic [15:0] eff_addr;
   logic offchip;
   logic hi_driven;

   assign take = move_req_in && (state == ST_IDLE);
   // short moves borrow the upper byte from bank select
   assign eff_addr = move_wide_in ? move_addr_in : {bank_reg, move_addr_in[7:0]};

   always_comb begin
      case (mode_field)
         MODE_ONCHIP: offchip = 1'b0;
         MODE_SPLIT: offchip = (eff_addr >= XRAM_SIZE);
         MODE_SPLIT_BANK: offchip = (eff_addr >= XRAM_SIZE);
         default: offchip = 1'b1;
      endcase
   end

   // upper byte is left to the port latches unless the move is wide or
   // the bank-select mode is active
   assign hi_driven = move_wide_in || (mode_field == MODE_SPLIT_BANK);

   // ==========================================================
   // sequencer
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic we_q;
   logic hi_q;
   logic [7:0] wdata_q;
   logic [15:0] next_addr;

   assign next_addr = take ? eff_addr : addr_out;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = offchip ? ST_ADDR : ST_ONCHIP;
            end
         end
         ST_ADDR: begin
            if (!separate_pins) begin
               next_state = ST_ALE_HI;
               next_cnt = {2'h0, ale_field};
            end else if (setup_field != 2'h0) begin
               next_state = ST_SETUP;
               next_cnt = {2'h0, setup_field - 2'h1};
            end else begin
               next_state = ST_STROBE;
               next_cnt = width_field;
            end
         end
         ST_ALE_HI: begin
            if (cnt == 4'h0) begin
               next_state = ST_ALE_LO;
               next_cnt = {2'h0, ale_field};
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         ST_ALE_LO: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if (setup_field != 2'h0) begin
               next_state = ST_SETUP;
               next_cnt = {2'h0, setup_field - 2'h1};
            end else begin
               next_state = ST_STROBE;
               next_cnt = width_field;
            end
         end
         ST_SETUP: begin
            if (cnt == 4'h0) begin
               next_state = ST_STROBE;
               next_cnt = width_field;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         ST_STROBE: begin
            if (cnt != 4'h0) begin
               next_cnt = cnt - 4'h1;
            end else if (hold_field != 2'h0) begin
               next_state = ST_HOLD;
               next_cnt = {2'h0, hold_field - 2'h1};
            end else begin
               next_state = ST_RECOV;
            end
         end
         ST_HOLD: begin
            if (cnt == 4'h0) begin
               next_state = ST_RECOV;
            end else begin
               next_cnt = cnt - 4'h1;
            end
         end
         ST_RECOV: next_state = ST_IDLE;
         ST_ONCHIP: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
      end else if (ce_in) begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ==========================================================
   // per-move capture
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         we_q <= 1'b0;
         hi_q <= 1'b0;
         wdata_q <= 8'h00;
         addr_out <= 16'h0000;
      end else if (ce_in && take) begin
         we_q <= move_write_in;
         hi_q <= hi_driven;
         wdata_q <= move_wdata_in;
         addr_out <= eff_addr;
      end
   end

   // ==========================================================
   // strobes and latch enable
   logic next_in_access;
   logic next_addr_phase;
   logic next_data_phase;
   logic next_we;

   // address stands from the first cycle through the hold phase
   assign next_in_access = next_state inside {ST_ADDR, ST_ALE_HI, ST_ALE_LO, ST_SETUP,
                                              ST_STROBE, ST_HOLD};
   assign next_addr_phase = next_state inside {ST_ADDR, ST_ALE_HI, ST_ALE_LO};
   assign next_data_phase = next_state inside {ST_SETUP, ST_STROBE, ST_HOLD};
   assign next_we = take ? move_write_in : we_q;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         ale_out <= 1'b0;
         rd_n_out <= 1'b1;
         wr_n_out <= 1'b1;
      end else if (ce_in) begin
         ale_out <= (next_state == ST_ALE_HI);
         rd_n_out <= !((next_state == ST_STROBE) && !next_we);
         wr_n_out <= !((next_state == ST_STROBE) && next_we);
      end
   end

   // ==========================================================
   // address and data pins
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         addr_lo_oe_n_out <= 1'b1;
         addr_hi_oe_n_out <= 1'b1;
         ad_out <= 8'h00;
         ad_oe_n_out <= 1'b1;
      end else if (ce_in) begin
         addr_lo_oe_n_out <= !(next_in_access && separate_pins);
         addr_hi_oe_n_out <= !(next_in_access && (take ? hi_driven : hi_q));
         if (next_addr_phase && !separate_pins) begin
            // latch follows while enable is high and holds after it falls
            ad_out <= next_addr[7:0];
            ad_oe_n_out <= 1'b0;
         end else if (next_data_phase && next_we) begin
            // write data spans setup, strobe and hold
            ad_out <= wdata_q;
            ad_oe_n_out <= 1'b0;
         end else begin
            ad_oe_n_out <= 1'b1;
         end
      end
   end

   // ==========================================================
   // read capture and completion
   // the synchroniser lags two cycles, so the sample taken in the last
   // strobe cycle shows the pins two cycles before the strobe rises;
   // memories must meet the read data setup time for that reason
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         move_rdata_out <= 8'h00;
      end else if (ce_in && (state == ST_STROBE) && (cnt == 4'h0) && !we_q) begin
         move_rdata_out <= ad_sync;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         move_busy_out <= 1'b0;
         move_done_out <= 1'b0;
         onchip_sel_out <= 1'b0;
      end else if (ce_in) begin
         move_busy_out <= (next_state != ST_IDLE);
         move_done_out <= (state == ST_RECOV) || (state == ST_ONCHIP);
         onchip_sel_out <= (next_state == ST_ONCHIP);
      end
   end

endmodule : ext_mem_strobe_timing

// file: logic/ext_mem_pkg.sv
/*
 * Constants for the external memory strobe timing block: special function
 * register addresses, field positions, reset values, memory modes and the
 * one-hot sequencer states.
 * Assumes a single 125 MHz system clock and an 8-bit register port.
 */
package ext_mem_pkg;

   // ==========================================================
   // register addresses and reset values
   localparam logic [7:0] TIMING_ADDR = 8'h84;
   localparam logic [7:0] CONFIG_ADDR = 8'h85;
   localparam logic [7:0] BANK_ADDR = 8'haa;
   localparam logic [7:0] TIMING_RESET = 8'hff;
   localparam logic [7:0] CONFIG_RESET = 8'h03;
   localparam logic [7:0] BANK_RESET = 8'h00;
   // only bits 4:0 of the configuration register hold state
   localparam logic [7:0] CONFIG_RW_MASK = 8'h1f;

   // ==========================================================
   // field positions
   localparam int SETUP_MSB = 7;
   localparam int SETUP_LSB = 6;
   localparam int WIDTH_MSB = 5;
   localparam int WIDTH_LSB = 2;
   localparam int HOLD_MSB = 1;
   localparam int HOLD_LSB = 0;
   localparam int MUX_BIT = 4;
   localparam int MODE_MSB = 3;
   localparam int MODE_LSB = 2;
   localparam int ALE_MSB = 1;
   localparam int ALE_LSB = 0;

   // ==========================================================
   // memory modes and address map
   localparam logic [1:0] MODE_ONCHIP = 2'h0;
   localparam logic [1:0] MODE_SPLIT = 2'h1;
   localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
   localparam logic [1:0] MODE_EXTERNAL = 2'h3;
   localparam logic [15:0] XRAM_SIZE = 16'h1000;
   // fixed overhead of every off-chip move, in system clock cycles
   localparam int FIXED_CYCLES = 4;
   localparam int SYNC_STAGES = 2;

   // ==========================================================
   // sequencer states
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_ADDR = 9'h002,
      ST_ALE_HI = 9'h004,
      ST_ALE_LO = 9'h008,
      ST_SETUP = 9'h010,
      ST_STROBE = 9'h020,
      ST_HOLD = 9'h040,
      ST_RECOV = 9'h080,
      ST_ONCHIP = 9'h100
   } seq_state_t;

endpackage : ext_mem_pkg

// file: logic/ext_mem_pin_sync.sv
/*
 * Two-stage synchroniser for the shared address/data input pins.
 * Assumes the pins are asynchronous to sys_clk_in; the first stage feeds
 * only the second stage.
 */
module ext_mem_pin_sync (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [7:0] pin_in,
   output logic [7:0] sync_out
);
   import ext_mem_pkg::*;

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         logic [SYNC_STAGES-1:0] stage;
         always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
               stage <= '0;
            end else if (ce_in) begin
               stage <= {stage[SYNC_STAGES-2:0], pin_in[i]};
            end
         end
         assign sync_out[i] = stage[SYNC_STAGES-1];
      end
   endgenerate

endmodule : ext_mem_pin_sync

// file: logic/ext_mem_regs.sv
/*
 * Special function registers of the external memory interface: timing,
 * configuration and bank select, on the core's 8-bit register port.
 * Assumes one-cycle write and read strobes; read data is registered.
 */
module ext_mem_regs (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   output logic [7:0] timing_out,
   output logic [7:0] config_out,
   output logic [7:0] bank_out
);
   import ext_mem_pkg::*;

   // ==========================================================
   // register writes
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         timing_out <= TIMING_RESET;
         config_out <= CONFIG_RESET;
         bank_out <= BANK_RESET;
      end else if (ce_in && sfr_wr_in) begin
         case (sfr_addr_in)
            TIMING_ADDR: timing_out <= sfr_wdata_in;
            // unused and reserved bits never store, so they read zero
            CONFIG_ADDR: config_out <= sfr_wdata_in & CONFIG_RW_MASK;
            BANK_ADDR: bank_out <= sfr_wdata_in;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // register reads, zero from any other address
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (ce_in && sfr_rd_in) begin
         case (sfr_addr_in)
            TIMING_ADDR: sfr_rdata_out <= timing_out;
            CONFIG_ADDR: sfr_rdata_out <= config_out;
            BANK_ADDR: sfr_rdata_out <= bank_out;
            default: sfr_rdata_out <= 8'h00;
         endcase
      end
   end

endmodule : ext_mem_regs

// file: tb/ext_mem_strobe_timing_assertions.sv
/*
 * Checker for the strobe timing block: shadows the registers from the
 * register port and ties strobe, latch and data pins to those values.
 * Assumes it is bound to ext_mem_strobe_timing and that software leaves
 * the registers alone while a move is in flight.
 */
module ext_mem_strobe_timing_checker (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic move_req_in,
   input wire logic move_wide_in,
   input wire logic [15:0] move_addr_in,
   input wire logic [7:0] move_wdata_in,
   input wire logic move_busy_out,
   input wire logic move_done_out,
   input wire logic onchip_sel_out,
   input wire logic [15:0] addr_out,
   input wire logic addr_lo_oe_n_out,
   input wire logic addr_hi_oe_n_out,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe_n_out,
   input wire logic ale_out,
   input wire logic rd_n_out,
   input wire logic wr_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import ext_mem_pkg::*;
   logic [7:0] tim, cfg, bnk, wdat, alo;
   logic [5:0] mv_cnt, lo_cnt, al_cnt;
   logic [3:0] wr_age;
   logic oc_seen, ale_q, wr_q;
   wire logic take = move_req_in && ce_in && (!move_busy_out || move_done_out);
   wire logic strobe_n = rd_n_out & wr_n_out;
   wire logic [5:0] exp_len = 6'(FIXED_CYCLES + 1) + 6'(tim[7:6]) + 6'(tim[5:2])
      + 6'(tim[1:0]) + (cfg[MUX_BIT] ? 6'h0 : 6'({cfg[1:0], 1'b0}) + 6'h2);

   // ==========================================================
   // register shadows
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         tim <= TIMING_RESET;
         cfg <= CONFIG_RESET;
         bnk <= BANK_RESET;
      end else if (sfr_wr_in && ce_in) begin
         if (sfr_addr_in == TIMING_ADDR) tim <= sfr_wdata_in;
         if (sfr_addr_in == CONFIG_ADDR) cfg <= sfr_wdata_in & CONFIG_RW_MASK;
         if (sfr_addr_in == BANK_ADDR) bnk <= sfr_wdata_in;
      end
   end

   // ==========================================================
   // phase counters; the strobe counter clears while high, the others saturate so idle stretches cannot wrap
   always_ff @(posedge sys_clk_in) begin
      ale_q <= ale_out;
      wr_q <= wr_n_out;
      lo_cnt <= strobe_n ? 6'h0 : lo_cnt + 6'h1;
      al_cnt <= (ale_out != ale_q) ? 6'h1 : al_cnt + 6'(al_cnt != 6'h3f);
      wr_age <= (wr_n_out && !wr_q) ? 4'h1 : wr_age + 4'(wr_age != 4'hf);
      mv_cnt <= take ? 6'h2 : mv_cnt + 6'(mv_cnt != 6'h3f);
      oc_seen <= take ? 1'b0 : oc_seen | onchip_sel_out;
      if (take) wdat <= move_wdata_in;
      if (take) alo <= move_addr_in[7:0];
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_quiet;
      (strobe_n && !ale_out)[*3];
   endsequence
   sequence s_done3;
      ##2 move_done_out;
   endsequence

   property p_strobe_width;
      $rose(strobe_n) |-> lo_cnt == 6'(tim[5:2]) + 6'h1;
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
   property p_move_len;
      (move_done_out && !oc_seen && !onchip_sel_out) |-> mv_cnt == exp_len;
   endproperty
   a_move_len: assert property (p_move_len) else $error("move length wrong");
   property p_ale_high;
      $fell(ale_out) |-> al_cnt == 6'(cfg[1:0]) + 6'h1;
   endproperty
   a_ale_high: assert property (p_ale_high) else $error("latch high time wrong");
   property p_ale_low;
      ($fell(strobe_n) && !cfg[MUX_BIT]) |-> al_cnt == 6'(cfg[1:0]) + 6'(tim[7:6]) + 6'h1;
   endproperty
   a_ale_low: assert property (p_ale_low) else $error("latch low phase wrong");
   property p_wdata;
      !wr_n_out |-> !ad_oe_n_out && ad_out == wdat;
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data not driven");
   property p_wdata_hold;
      ($rose(ad_oe_n_out) && cfg[MUX_BIT]) |-> ($rose(wr_n_out) ? 4'h0 : wr_age) == tim[1:0];
   endproperty
   a_wdata_hold: assert property (p_wdata_hold) else $error("write data hold wrong");
   property p_onchip;
      (take && cfg[MODE_MSB:MODE_LSB] == MODE_ONCHIP) |-> s_quiet and s_done3;
   endproperty
   a_onchip: assert property (p_onchip) else $error("on-chip move left the pins");
   property p_bank;
      (take && !move_wide_in && cfg[MODE_MSB:MODE_LSB] == MODE_SPLIT_BANK && bnk >= 8'h10)
         |=> addr_out == {bnk, alo} && !addr_hi_oe_n_out;
   endproperty
   a_bank: assert property (p_bank) else $error("bank byte not on upper address");
   property p_pins;
      cfg[MUX_BIT] ? !ale_out : addr_lo_oe_n_out;
   endproperty
   a_pins: assert property (p_pins) else $error("pin mode wrong");
   property p_shared_addr;
      ale_out |-> !ad_oe_n_out && ad_out == addr_out[7:0];
   endproperty
   a_shared_addr: assert property (p_shared_addr) else $error("low address missing");
endmodule : ext_mem_strobe_timing_checker

bind ext_mem_strobe_timing ext_mem_strobe_timing_checker u_chk (.sys_clk_in, .rst_n_in,
   .ce_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in, .move_req_in, .move_wide_in,
   .move_addr_in, .move_wdata_in, .move_busy_out, .move_done_out, .onchip_sel_out,
   .addr_out, .addr_lo_oe_n_out, .addr_hi_oe_n_out, .ad_out, .ad_oe_n_out, .ale_out,
   .rd_n_out, .wr_n_out);

// file: tb/ext_mem_model.sv
/*
 * External byte-wide memory with an address latch for the shared pins.
 * Assumes registered strobes from the interface; keyed by the low byte.
 */
module ext_mem_model (
   input wire logic sys_clk_in,
   input wire logic [15:0] addr_in,
   input wire logic addr_lo_oe_n_in,
   input wire logic [7:0] ad_pins_in,
   input wire logic ale_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   output logic [7:0] ad_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] latch_q, last;
   wire logic [7:0] a = !addr_lo_oe_n_in ? addr_in[7:0] : latch_q;
   // transparent while latch enable is high, frozen once it falls
   always_latch if (ale_in) latch_q <= ad_pins_in;
   always_ff @(posedge sys_clk_in) begin
      if (!wr_n_in) mem[a] <= ad_pins_in;
      if (!rd_n_in) last <= mem[a];
   end
   // released pins show the inverse so a stale value cannot pass
   assign ad_out = !rd_n_in ? mem[a] : ~last;
endmodule : ext_mem_model

// file: tb/tb_top.sv
/*
 * Bench for the strobe timing block: register checks, a table of moves
 * with their cycle counts and read data, then bank select and reset.
 * Assumes the memory model on the pins and the bound checker.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ext_mem_pkg::*;
   typedef struct {
      logic [7:0] tim;
      logic [7:0] cfg;
      logic wr;
      logic wide;
      logic [15:0] addr;
      logic [7:0] data;
   } row_t;
   logic sys_clk_in, rst_n_in, ce_in, sfr_wr_in, sfr_rd_in, move_req_in, move_write_in;
   logic move_wide_in, move_busy_out, move_done_out, onchip_sel_out, addr_lo_oe_n_out;
   logic addr_hi_oe_n_out, ad_oe_n_out, ale_out, rd_n_out, wr_n_out;
   logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, move_wdata_in, move_rdata_out;
   logic [7:0] ad_out, ad_in, d;
   logic [15:0] move_addr_in, addr_out, a;
   logic oc;
   row_t bank_row = '{8'h00, 8'h18, 1, 0, 16'h0077, 8'h99};
   int error_cnt, n_tests, cyc;
   // off-chip reads use a three-cycle strobe so the pins settle before capture
   row_t rows [11] = '{'{8'h02, 8'h1f, 1, 1, 16'h1234, 8'ha5},
      '{8'h08, 8'h1c, 0, 1, 16'h1234, 8'ha5}, '{8'h00, 8'h0c, 1, 1, 16'h2056, 8'h3c},
      '{8'h08, 8'h0d, 0, 1, 16'h2056, 8'h3c}, '{8'hff, 8'h0f, 1, 1, 16'h30aa, 8'h77},
      '{8'h4a, 8'h17, 0, 1, 16'h30aa, 8'h77}, '{8'h00, 8'h10, 1, 1, 16'h30aa, 8'h00},
      '{8'h00, 8'h14, 0, 1, 16'h0100, 8'h00}, '{8'h00, 8'h1a, 1, 1, 16'h5000, 8'h11},
      '{8'h08, 8'h06, 0, 1, 16'h5000, 8'h11}, '{8'h00, 8'h09, 1, 1, 16'h6001, 8'h22}};

   ext_mem_strobe_timing DUT (.sys_clk_in, .rst_n_in, .ce_in, .sfr_addr_in, .sfr_wr_in,
      .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .move_req_in, .move_write_in,
      .move_wide_in, .move_addr_in, .move_wdata_in, .move_busy_out, .move_done_out,
      .move_rdata_out, .onchip_sel_out, .addr_out, .addr_lo_oe_n_out, .addr_hi_oe_n_out,
      .ad_out, .ad_oe_n_out, .ad_in, .ale_out, .rd_n_out, .wr_n_out);
   ext_mem_model u_mem (.sys_clk_in, .addr_in(addr_out), .addr_lo_oe_n_in(addr_lo_oe_n_out),
      .ad_pins_in(ad_out), .ale_in(ale_out), .rd_n_in(rd_n_out), .wr_n_in(wr_n_out),
      .ad_out(ad_in));

   always #4 sys_clk_in = ~sys_clk_in;

   // ==========================================================
   // tasks
   task automatic results();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic sfr_write(input logic [7:0] ad, input logic [7:0] wd);
      @(posedge sys_clk_in);
      sfr_addr_in <= ad;
      sfr_wdata_in <= wd;
      sfr_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      sfr_wr_in <= 1'b0;
   endtask : sfr_write
   task automatic sfr_read(input logic [7:0] ad);
      @(posedge sys_clk_in);
      sfr_addr_in <= ad;
      sfr_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      sfr_rd_in <= 1'b0;
      #1 d = sfr_rdata_out;
   endtask : sfr_read
   task automatic do_move(input row_t r);
      @(posedge sys_clk_in);
      move_req_in <= 1'b1;
      move_write_in <= r.wr;
      move_wide_in <= r.wide;
      move_addr_in <= r.addr;
      move_wdata_in <= r.data;
      @(posedge sys_clk_in);
      move_req_in <= 1'b0;
      cyc = 2;
      #1 a = addr_out;
      oc = onchip_sel_out;
      check("busy", move_busy_out, 16'h1);
      while (move_done_out !== 1'b1 && cyc < 60) begin
         @(posedge sys_clk_in);
         #1 cyc++;
      end
      if (cyc >= 60) begin
         error_cnt++;
         results();
      end
      check("idle", move_busy_out, 16'h0);
   endtask : do_move
   function automatic int exp_len(input row_t r, input logic [7:0] bank);
      logic [15:0] eff;
      eff = r.wide ? r.addr : {bank, r.addr[7:0]};
      if (r.cfg[3:2] == MODE_ONCHIP || (r.cfg[3:2] != MODE_EXTERNAL && eff < XRAM_SIZE))
         return 3;
      return FIXED_CYCLES + 1 + r.tim[7:6] + r.tim[5:2] + r.tim[1:0]
         + (r.cfg[4] ? 0 : 2 * (r.cfg[1:0] + 1));
   endfunction : exp_len

   // ==========================================================
   // main sequence
   initial begin
      {sys_clk_in, rst_n_in, sfr_wr_in, sfr_rd_in, move_req_in, move_write_in} = '0;
      {move_wide_in, sfr_addr_in, sfr_wdata_in, move_wdata_in, move_addr_in} = '0;
      ce_in = 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      sfr_read(TIMING_ADDR);
      check("timing", d, 8'hff);
      sfr_read(CONFIG_ADDR);
      check("config", d, 8'h03);
      sfr_read(BANK_ADDR);
      check("bank", d, 8'h00);
      sfr_write(8'h90, 8'h5a);
      sfr_read(8'h90);
      check("unmapped", d, 8'h00);
      for (int i = 0; i < 11; i++) begin
         sfr_write(TIMING_ADDR, rows[i].tim);
         sfr_write(CONFIG_ADDR, rows[i].cfg);
         sfr_read(TIMING_ADDR);
         check("timing", d, rows[i].tim);
         do_move(rows[i]);
         check("cycles", 16'(cyc), 16'(exp_len(rows[i], 8'h00)));
         check("on-chip", oc, 16'(exp_len(rows[i], 8'h00) == 3));
         if (exp_len(rows[i], 8'h00) > 3) check("address", a, rows[i].addr);
         if (!rows[i].wr && exp_len(rows[i], 8'h00) > 3)
            check("read data", move_rdata_out, rows[i].data);
      end
      // narrow move in bank mode picks up the bank byte
      sfr_write(TIMING_ADDR, 8'h00);
      sfr_write(CONFIG_ADDR, 8'h18);
      sfr_write(BANK_ADDR, 8'h40);
      do_move(bank_row);
      check("bank address", a, 16'h4077);
      check("cycles", 16'(cyc), 16'(exp_len(bank_row, 8'h40)));
      // a write while the clock enable is low must not store
      @(posedge sys_clk_in);
      ce_in <= 1'b0;
      sfr_write(TIMING_ADDR, 8'h12);
      ce_in <= 1'b1;
      sfr_read(TIMING_ADDR);
      check("frozen timing", d, 8'h00);
      // second reset in mid-run restores the maximum delays
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      sfr_read(TIMING_ADDR);
      check("timing", d, 8'hff);
      sfr_read(CONFIG_ADDR);
      check("config", d, 8'h03);
      sfr_read(BANK_ADDR);
      check("bank", d, 8'h00);
      results();
   end
endmodule : tb_top
